/* File: dds_core.sv */
// Purpose: Synthesizer end: serial port, word registers, oscillator, sign pin.
// Assumes: Pins are synchronous to mclk; sclk is sampled, not used as a clock.
// Notes:   A word commits on its sixteenth sampled sclk fall; rules follow.
// Operation
// RULE1 - accumulator uses pin-selected frequency word
// RULE2 - frequency word chosen by pin or bit
// RULE3 - pin-selected phase offset added to accumulator
// RULE4 - phase offset chosen by pin or bit
// RULE5 - reset pin clears datapath to zero
// RULE6 - reset pin keeps host registers intact
// RULE7 - sleep pin powers down converter
// RULE8 - sleep pin equals powerdown control bit
// RULE9 - each frame carries one 16-bit word
// RULE10 - sample data on falling serial clock
// RULE11 - falling frame sync starts new word
// RULE12 - sign pin driven only when enabled
// RULE13 - source bit picks comparator or phase msb
// RULE14 - comparator uses external pin when both set
// RULE15 - output frequency binary fraction of mclk
// RULE16 - 28-bit accumulator adds word each mclk
// RULE17 - 12-bit offset added to accumulator msbs
// RULE18 - commit after sixteenth edge, ignore extras
`timescale 1ns/1ns
module dds_core
  import dds_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               arst_n,
  // Pins from the host
  dds_link_if.device              link,
  // Analog side
  input  wire logic               comparator_input_pin,
  input  wire logic               internal_cmp_in,
  output logic [PHASE_W-1:0]      phase_out,
  output logic                    dac_powerdown,
  output logic                    comparator_from_pin,
  output logic [ACC_W-1:0]        frequency_word_a,
  output logic [ACC_W-1:0]        frequency_word_b
);
  // ==========================================================================
  // Elaboration checks
  // The counter must reach the word length and the fields of a word must not overlap.
  if ((1 << BITCNT_W) <= WORD_W) begin : g_bad_count
    $error("bit counter too narrow for one word");
  end
  if (PHASE_W > ACC_W || 2 * HALF_W != ACC_W) begin : g_bad_acc
    $error("accumulator and offset widths disagree");
  end
  if (HALF_BIT != HALF_W - 2 || WSEL_BIT <= HALF_BIT || DEST_LO <= WSEL_BIT) begin : g_bad_word
    $error("word fields overlap");
  end
  if (CTL_W > HALF_BIT || CTL_SQSRC_BIT >= CTL_W || DEST_HI != WORD_W - 1) begin : g_bad_ctl
    $error("control field does not fit the word");
  end

  // ==========================================================================
  // Serial port
  logic                 sclk_reg;
  logic                 frame_sync_n_reg;
  logic [WORD_W-1:0]    shift_reg;
  logic [BITCNT_W-1:0]  count_reg;
  logic [CTL_W-1:0]     ctrl_reg;
  logic [PHASE_W-1:0]   phase_offset_a;
  logic [PHASE_W-1:0]   phase_offset_b;
  logic [ACC_W-1:0]     acc_reg;

  wire sclk_fall   = sclk_reg & ~link.sclk;
  wire frame_sync_n_fall  = frame_sync_n_reg & ~link.frame_sync_n;
  wire in_frame    = ~link.frame_sync_n;
  // A fresh frame restarts the count even if the last one was cut short.
  wire [BITCNT_W-1:0] count_base = frame_sync_n_fall ? '0 : count_reg; // RULE11
  wire take_bit    = in_frame & sclk_fall & (count_base != BITCNT_W'(WORD_W)); // RULE10 RULE18
  wire [WORD_W-1:0] shift_next = {shift_reg[WORD_W-2:0], link.serial_data_in};
  wire commit      = take_bit & (count_base == BITCNT_W'(WORD_W - 1)); // RULE9 RULE18
  wire [1:0] dest  = shift_next[DEST_HI:DEST_LO];

  // Edge detectors start at the idle pin levels, so no false edge follows reset.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_reg  <= 1'b1;
      frame_sync_n_reg <= 1'b1;
    end else begin
      sclk_reg  <= link.sclk;
      frame_sync_n_reg <= link.frame_sync_n;
    end
  end

  // ==========================================================================
  // Shift register and bit count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= '0;
      count_reg <= '0;
    end else begin
      if (take_bit) begin
        shift_reg <= shift_next;
        count_reg <= count_base + BITCNT_W'(1);
      end else begin
        count_reg <= count_base;
      end
    end
  end

  // ==========================================================================
  // Destination decode for a committed word
  wire               pick_b   = shift_next[WSEL_BIT];
  wire               pick_hi  = shift_next[HALF_BIT];
  wire               is_ctrl  = commit & (dest == DEST_CTRL);
  wire               is_freq  = commit & (dest == DEST_FREQ);
  wire               is_phase = commit & (dest == DEST_PHASE);
  wire               wr_a_lo  = is_freq & ~pick_b & ~pick_hi;
  wire               wr_a_hi  = is_freq & ~pick_b & pick_hi;
  wire               wr_b_lo  = is_freq & pick_b & ~pick_hi;
  wire               wr_b_hi  = is_freq & pick_b & pick_hi;
  wire               wr_ofs_a = is_phase & ~pick_b;
  wire               wr_ofs_b = is_phase & pick_b;
  // A half write leaves the other half alone, so a word changes in two steps.
  // Short payloads are zero-extended; the spare destination is dropped.
  wire [HALF_W-1:0]  half_val = {2'h0, shift_next[HALF_BIT-1:0]};
  wire [PHASE_W-1:0] ofs_val  = shift_next[PHASE_W-1:0];
  wire [CTL_W-1:0]   ctl_val  = shift_next[CTL_W-1:0];

  // ==========================================================================
  // Host registers; the reset pin never touches them.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg         <= CTL_RESET;
      frequency_word_a <= '0;
      frequency_word_b <= '0;
      phase_offset_a   <= '0;
      phase_offset_b   <= '0;
    end else begin
      if (is_ctrl)
        ctrl_reg <= ctl_val; // RULE6
      if (wr_a_hi)
        frequency_word_a[ACC_W-1:HALF_W] <= half_val;
      if (wr_a_lo)
        frequency_word_a[HALF_W-1:0] <= half_val;
      if (wr_b_hi)
        frequency_word_b[ACC_W-1:HALF_W] <= half_val;
      if (wr_b_lo)
        frequency_word_b[HALF_W-1:0] <= half_val;
      if (wr_ofs_a)
        phase_offset_a <= ofs_val;
      if (wr_ofs_b)
        phase_offset_b <= ofs_val;
    end
  end

  // ==========================================================================
  // Oscillator
  // Control bit CTL_PINSEL chooses pins (1) or control bits (0) as select source.
  wire use_pins  = ctrl_reg[CTL_PINSEL_BIT];
  wire freq_word_select_bit      = use_pins ? link.freq_word_select_pin : ctrl_reg[CTL_FREQ_WORD_SELECT_BIT_BIT]; // RULE1 RULE2
  wire psel      = use_pins ? link.phase_word_select_pin : ctrl_reg[CTL_PSEL_BIT]; // RULE3 RULE4
  wire [ACC_W-1:0]   freq_sel  = freq_word_select_bit ? frequency_word_b : frequency_word_a;
  wire [PHASE_W-1:0] phase_sel = psel ? phase_offset_b : phase_offset_a;
  wire [PHASE_W-1:0] phase_sum = acc_reg[ACC_W-1 -: PHASE_W] + phase_sel; // RULE17

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg   <= '0;
      phase_out <= '0;
    end else if (link.reset_pin) begin
      acc_reg   <= '0; // RULE5
      phase_out <= '0;
    end else begin
      acc_reg   <= acc_reg + freq_sel; // RULE15 RULE16
      phase_out <= phase_sum;
    end
  end

  // ==========================================================================
  // Power-down and sign output
  wire en_bit   = ctrl_reg[CTL_OPEN_BIT];
  wire src_bit  = ctrl_reg[CTL_SQSRC_BIT];
  wire cmp_pin  = en_bit & src_bit; // RULE14
  wire cmp_val  = cmp_pin ? comparator_input_pin : internal_cmp_in;
  wire sign_val = src_bit ? cmp_val : phase_sum[PHASE_W-1]; // RULE13

  wire pd_next   = link.sleep_pin | ctrl_reg[CTL_PD_BIT]; // RULE7 RULE8
  // The pin is held low while disabled, so a late enable never shows a stale level.
  wire sign_next = en_bit & sign_val; // RULE12

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dac_powerdown       <= 1'b0;
      comparator_from_pin <= 1'b0;
    end else begin
      dac_powerdown       <= pd_next;
      comparator_from_pin <= cmp_pin;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.sign_out    <= 1'b0;
      link.sign_out_oe <= 1'b0;
    end else begin
      link.sign_out    <= sign_next;
      link.sign_out_oe <= en_bit; // RULE12
    end
  end
endmodule

/* File: dds_pkg.sv */
// Purpose: Shared constants for the synthesizer pin control and serial port.
// Assumes: One clock, mclk at 100 MHz.
// Notes:   Word layout: bits 15:14 select the destination, bits 13:0 are payload.
package dds_pkg;
  // ==========================================================================
  // Widths
  localparam int ACC_W      = 28;
  localparam int PHASE_W    = 12;
  localparam int WORD_W     = 16;
  localparam int BITCNT_W   = 5;
  // ==========================================================================
  // Serial word destinations in bits 15:14
  localparam int            DEST_HI  = 15;
  localparam int            DEST_LO  = 14;
  localparam logic [1:0]    DEST_CTRL = 2'h0;
  localparam logic [1:0]    DEST_FREQ = 2'h1;
  localparam logic [1:0]    DEST_PHASE = 2'h2;
  localparam logic [1:0]    DEST_SPARE = 2'h3;
  // Frequency and phase words: bit 13 picks word a or b.
  localparam int            WSEL_BIT = 13;
  // Frequency halves: bit 12 picks upper (1) or lower (0) 14 bits.
  localparam int            HALF_BIT = 12;
  localparam int            HALF_W   = 14;
  // ==========================================================================
  // Control word field positions
  localparam int            CTL_FREQ_WORD_SELECT_BIT_BIT   = 0;
  localparam int            CTL_PSEL_BIT   = 1;
  localparam int            CTL_PINSEL_BIT = 2;
  localparam int            CTL_PD_BIT     = 3;
  localparam int            CTL_OPEN_BIT   = 4;
  localparam int            CTL_SQSRC_BIT  = 5;
  localparam int            CTL_W          = 6;
  localparam logic [5:0]    CTL_RESET      = 6'h00;
  // ==========================================================================
  // Host register offsets on APB
  localparam logic [7:0]    OFS_TXWORD = 8'h00;
  localparam logic [7:0]    OFS_STATUS = 8'h04;
  localparam logic [7:0]    OFS_PINS   = 8'h08;
  localparam int            ST_BUSY_BIT = 0;
  localparam int            PIN_FREQ_WORD_SELECT_BIT_BIT = 0;
  localparam int            PIN_PSEL_BIT = 1;
  localparam int            PIN_RST_BIT  = 2;
  localparam int            PIN_SLEEP_BIT = 3;
  localparam int            PIN_W         = 4;
  // ==========================================================================
  // Serial clock: half period in mclk cycles
  localparam int            SCLK_HALF_NS  = 20;
  localparam int            CLK_NS        = 10;
  localparam int            SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
endpackage

/* File: dds_link_if.sv */
// Purpose: Pin bundle between the host controller and the synthesizer.
// Assumes: Host drives every pin except the sign output.
// Notes:   The sign output is three-state; enable high means driven.
`timescale 1ns/1ns
interface dds_link_if;
  logic serial_data_in;
  logic sclk;
  logic frame_sync_n;
  logic freq_word_select_pin;
  logic phase_word_select_pin;
  logic reset_pin;
  logic sleep_pin;
  logic sign_out;
  logic sign_out_oe;
  modport device (
    input  serial_data_in, sclk, frame_sync_n, freq_word_select_pin,
    input  phase_word_select_pin, reset_pin, sleep_pin,
    output sign_out, sign_out_oe
  );
  modport host (
    output serial_data_in, sclk, frame_sync_n, freq_word_select_pin,
    output phase_word_select_pin, reset_pin, sleep_pin,
    input  sign_out, sign_out_oe
  );
endinterface

/* File: dds_host.sv */
// Purpose: Host end: APB slave that sends 16-bit serial words and drives pins.
// Assumes: One mclk; sclk derived by a divider enable.
// Notes:   A write to the word register while busy is dropped.
`timescale 1ns/1ns
module dds_host
  import dds_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          arst_n,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Pins to the synthesizer
  dds_link_if.host           link
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_SHIFT = 2'b10,
    ST_END   = 2'b11
  } host_state_t;

  host_state_t          state_reg;
  logic [WORD_W-1:0]    word_reg;
  logic [BITCNT_W-1:0]  bits_reg;
  logic [3:0]           div_reg;
  logic [PIN_W-1:0]     pins_reg;

  // ==========================================================================
  // Register decode
  wire acc      = psel & penable;
  wire hit_tx   = paddr == OFS_TXWORD;
  wire hit_st   = paddr == OFS_STATUS;
  wire hit_pin  = paddr == OFS_PINS;
  wire unmapped = ~(hit_tx | hit_st | hit_pin);
  wire busy     = state_reg != ST_IDLE;
  wire start    = acc & pwrite & hit_tx & ~busy;
  wire tick     = div_reg == 4'(SCLK_HALF_CYC - 1);
  wire [31:0] rd_val = hit_st ? {31'h0, busy} :
                       hit_pin ? {28'h0, pins_reg} : 32'h0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0;
      pins_reg <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & unmapped;
      prdata  <= rd_val;
      if (acc && pready && pwrite && hit_pin)
        pins_reg <= pwdata[PIN_W-1:0];
    end
  end

  // ==========================================================================
  // Serial engine: frame low, 16 falling sclk edges, frame high.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg           <= ST_IDLE;
      word_reg            <= '0;
      bits_reg            <= '0;
      div_reg             <= '0;
      link.sclk           <= 1'b1;
      link.frame_sync_n   <= 1'b1;
      link.serial_data_in <= 1'b0;
    end else begin
      div_reg <= (tick || state_reg == ST_IDLE) ? 4'h0 : div_reg + 4'h1;
      unique case (state_reg)
        ST_IDLE: if (start && pready) begin
          word_reg          <= pwdata[WORD_W-1:0];
          bits_reg          <= '0;
          link.frame_sync_n <= 1'b0; // RULE11
          link.serial_data_in <= pwdata[WORD_W-1];
          state_reg         <= ST_SETUP;
        end
        ST_SETUP: if (tick) begin
          link.sclk <= 1'b0; // RULE10
          bits_reg  <= bits_reg + BITCNT_W'(1);
          state_reg <= ST_SHIFT;
        end
        ST_SHIFT: if (tick) begin
          if (link.sclk == 1'b0) begin
            link.sclk <= 1'b1;
            word_reg  <= {word_reg[WORD_W-2:0], 1'b0};
            link.serial_data_in <= word_reg[WORD_W-2];
            if (bits_reg == BITCNT_W'(WORD_W))
              state_reg <= ST_END;
          end else begin
            link.sclk <= 1'b0;
            bits_reg  <= bits_reg + BITCNT_W'(1); // RULE9
          end
        end
        ST_END: if (tick) begin
          link.frame_sync_n <= 1'b1;
          state_reg         <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link.freq_word_select_pin  <= 1'b0;
      link.phase_word_select_pin <= 1'b0;
      link.reset_pin             <= 1'b0;
      link.sleep_pin             <= 1'b0;
    end else begin
      // Held steady from a register, so pin-selected modes see a fixed level.
      link.freq_word_select_pin  <= pins_reg[PIN_FREQ_WORD_SELECT_BIT_BIT]; // RULE2
      link.phase_word_select_pin <= pins_reg[PIN_PSEL_BIT]; // RULE4
      link.reset_pin             <= pins_reg[PIN_RST_BIT];
      link.sleep_pin             <= pins_reg[PIN_SLEEP_BIT];
    end
  end
endmodule

/* File: dds_link_assertions.sv */
// Purpose: Protocol checks on the link between host and synthesizer.
// Assumes: One clock, mclk; arst_n is active low.
// Notes:   Sees the link signals only.
`timescale 1ns/1ns
module dds_link_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Link pins
  input wire logic serial_data_in,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic reset_pin,
  input wire logic sign_out_oe
);
  // ==========================================================================
  // Helper
  // Falls of sclk in the current frame; it saturates so a runaway host cannot wrap it.
  logic [4:0] fall_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) fall_reg <= 5'h00;
    else if ($fell(frame_sync_n)) fall_reg <= 5'h00;
    else if ($fell(sclk) && fall_reg != 5'h1F) fall_reg <= fall_reg + 5'h01;
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_idle; frame_sync_n |-> sclk; endproperty
  a_idle: assert property (p_idle) else $error("sclk low outside a frame");
  property p_bits; $rose(frame_sync_n) |-> fall_reg == 5'h10; endproperty
  a_bits: assert property (p_bits) else $error("frame not 16 bits");
  property p_hold; !sclk && $past(!sclk) |-> $stable(serial_data_in); endproperty
  a_hold: assert property (p_hold) else $error("data moved while sclk low");
  property p_low; $fell(sclk) |-> !sclk ##1 !sclk ##1 sclk; endproperty
  a_low: assert property (p_low) else $error("sclk low time wrong");
  property p_infr; $fell(sclk) |-> !frame_sync_n; endproperty
  a_infr: assert property (p_infr) else $error("sclk fell outside frame");
  property p_start; $fell(frame_sync_n) |-> sclk ##1 sclk; endproperty
  a_start: assert property (p_start) else $error("frame start not on high sclk");
  property p_gap; $rose(frame_sync_n) |=> frame_sync_n; endproperty
  a_gap: assert property (p_gap) else $error("no idle between frames");
  property p_oe; $rose(sign_out_oe) |-> fall_reg == 5'h10; endproperty
  a_oe: assert property (p_oe) else $error("sign enable without a whole word");
  property p_keep; reset_pin && frame_sync_n |=> ##1 $stable(sign_out_oe); endproperty
  a_keep: assert property (p_keep) else $error("reset pin changed control");
  c_frame: cover property ($fell(frame_sync_n));
  c_oe: cover property ($rose(sign_out_oe));
  c_rst: cover property (reset_pin ##1 reset_pin);
endmodule

/* File: tb.sv */
// Purpose: Drives the host over APB and checks the synthesizer end.
// Assumes: mclk 100 MHz; outputs compared at the falling edge.
// Notes:   Rate checks use the phase step, since absolute latency is open.
`timescale 1ns/1ns
module tb;
  import dds_pkg::*;
  // ==========================================================================
  // Signals
  logic               mclk = 1'b0;
  logic               arst_n = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               cmp_pin = 1'b0;
  logic               cmp_int = 1'b0;
  logic [PHASE_W-1:0] phase_out;
  logic               dac_powerdown;
  logic               comparator_from_pin;
  logic [ACC_W-1:0]   frequency_word_a;
  logic [ACC_W-1:0]   frequency_word_b;
  logic [31:0]        rd_data = 32'h0;
  logic               rd_err = 1'b0;
  logic [11:0]        pa;
  logic [11:0]        pb;
  logic [11:0]        fl;
  logic [31:0]        exp_q[$];
  int                 sel_q[$];
  int                 failures = 0;
  int                 check_count = 0;
  integer             seed = 32'h30CA;
  always #5 mclk = ~mclk;
  dds_link_if dds_link_if_inst ();
  dds_host dds_host_inst (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(dds_link_if_inst));
  dds_core dds_core_inst (.mclk(mclk), .arst_n(arst_n), .link(dds_link_if_inst),
    .comparator_input_pin(cmp_pin), .internal_cmp_in(cmp_int), .phase_out(phase_out),
    .dac_powerdown(dac_powerdown), .comparator_from_pin(comparator_from_pin),
    .frequency_word_a(frequency_word_a), .frequency_word_b(frequency_word_b));
  dds_link_assertions dds_link_assertions_inst (.mclk(mclk), .arst_n(arst_n),
    .serial_data_in(dds_link_if_inst.serial_data_in), .sclk(dds_link_if_inst.sclk),
    .frame_sync_n(dds_link_if_inst.frame_sync_n), .reset_pin(dds_link_if_inst.reset_pin),
    .sign_out_oe(dds_link_if_inst.sign_out_oe));
  // ==========================================================================
  // Tasks
  task automatic wrap_up;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] obs(input int sel);
    case (sel)
      0: return rd_data;
      1: return {4'h0, frequency_word_a};
      2: return {4'h0, frequency_word_b};
      3: return {20'h0, phase_out};
      4: return {31'h0, dac_powerdown};
      5: return {31'h0, comparator_from_pin};
      6: return {31'h0, dds_link_if_inst.sign_out_oe};
      8: return {31'h0, dds_link_if_inst.sign_out};
      default: return {31'h0, rd_err};
    endcase
  endfunction
  // The monitor takes each note at the next falling edge, where outputs are settled.
  always @(negedge mclk) begin
    while (exp_q.size() > 0) check(obs(sel_q.pop_front()), exp_q.pop_front());
  end
  task automatic expect_out(input int sel, input logic [31:0] exp);
    exp_q.push_back(exp);
    sel_q.push_back(sel);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      $display("ERROR %0t: bus timeout", $time);
      wrap_up();
    end else begin
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // A word sent while busy is dropped, so each send waits for the frame to finish.
  task automatic send(input logic [15:0] w);
    int n;
    apb(1'b1, OFS_TXWORD, {16'h0, w});
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd_data[ST_BUSY_BIT] !== 1'b0 && n < 60);
    if (rd_data[ST_BUSY_BIT] !== 1'b0) begin
      failures++;
      $display("ERROR %0t: link busy timeout", $time);
      wrap_up();
    end
    repeat (3) @(posedge mclk);
  endtask
  task automatic ctl(input logic [5:0] c);
    send({DEST_CTRL, 8'h00, c});
  endtask
  task automatic pins(input logic [3:0] v);
    apb(1'b1, OFS_PINS, {28'h0, v});
    repeat (4) @(posedge mclk);
  endtask
  task automatic rate(input logic [11:0] d);
    logic [11:0] p0;
    @(negedge mclk);
    p0 = phase_out + d;
    @(posedge mclk);
    expect_out(3, {20'h0, p0});
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b0, OFS_PINS, 32'h0);
    expect_out(0, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    expect_out(7, 32'h1);
    $display("test registers done");
    pa = 12'($random(seed));
    pb = 12'($random(seed));
    send({DEST_PHASE, 2'b00, pa});
    send({DEST_PHASE, 2'b10, pb});
    ctl(6'h04);
    for (int s = 0; s < 2; s++) begin
      pins({2'b00, s[0], 1'b0});
      expect_out(3, {20'h0, s[0] ? pb : pa});
    end
    ctl(6'h02);
    pins(4'h0);
    expect_out(3, {20'h0, pb});
    ctl(6'h00);
    $display("test phase select done");
    fl = 12'($random(seed));
    send({DEST_FREQ, 2'b00, fl});
    send({DEST_FREQ, 2'b01, 12'h004});
    expect_out(1, {4'h0, 14'h0004, 2'h0, fl});
    send({DEST_FREQ, 2'b00, 12'h000});
    send({DEST_FREQ, 2'b10, 12'h000});
    send({DEST_FREQ, 2'b11, 12'h00C});
    expect_out(2, 32'h0030000);
    rate(12'h001);
    ctl(6'h01);
    rate(12'h003);
    ctl(6'h04);
    pins(4'h1);
    rate(12'h003);
    pins(4'h0);
    rate(12'h001);
    pins(4'h4);
    expect_out(3, 32'h0);
    expect_out(1, 32'h0010000);
    pins(4'h0);
    $display("test frequency done");
    for (int k = 0; k < 4; k++) begin
      ctl({2'b00, k[1], 3'b000});
      pins({k[0], 3'b000});
      expect_out(4, {31'h0, k[0] | k[1]});
    end
    pins(4'h0);
    $display("test sleep done");
    // The reset pin holds the accumulator at zero, so the phase sign is the offset's top bit.
    pins(4'h4);
    for (int k = 0; k < 4; k++) begin
      cmp_pin <= 1'($random(seed));
      cmp_int <= 1'($random(seed));
      ctl({k[1], k[0], 4'h0});
      expect_out(6, {31'h0, k[0]});
      expect_out(5, {31'h0, k[0] & k[1]});
      expect_out(8, {31'h0, k[0] & (k[1] ? cmp_pin : pa[PHASE_W-1])});
    end
    pins(4'h0);
    $display("test sign pin done");
    repeat (2) @(posedge mclk);
    wrap_up();
  end
endmodule
